/* hdl/srps_regs.svh */
`ifndef SRPS_REGS_SVH
`define SRPS_REGS_SVH
`define SRPS_SEL_R0 4'h0
`define SRPS_SEL_R4 4'h4
`define SRPS_SEL_ADC 4'ha
`define SRPS_SEL_FIXED 4'hb
`define SRPS_SEL_RESYNC 4'hc
`define SRPS_ADC_DIV_HI 13
`define SRPS_ADC_DIV_LO 6
`define SRPS_CONV_BIT 5
`define SRPS_ADCPWR_BIT 4
`define SRPS_CLR_BIT 4
`define SRPS_CAL_BIT 21
`define SRPS_TMO_HI 31
`define SRPS_TMO_LO 16
`define SRPS_WORD_RST 32'h00000000
`define SRPS_R_RST 10'h001
`endif

/* hdl/srps_pkg.sv */
package srps_pkg;
  typedef logic [31:0] srps_word_t;
  typedef logic [3:0] srps_sel_t;
endpackage

/* hdl/srps_shift_in.sv */
`timescale 1ns/1ps
// Serial word capture: MSB first, select bits last, latched on load-enable rise
module srps_shift_in (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic sclk_in,
  input wire logic sdata_in,
  input wire logic le_in,
  output srps_pkg::srps_word_t word_out,
  output logic word_valid_out
);
  import srps_pkg::*;
  logic [2:0] s1_q, s2_q, s3_q;
  logic [2:0] s1_d, s2_d, s3_d;
  srps_word_t sh_q, sh_d, word_q, word_d;
  logic vld_q, vld_d;
  always_comb begin
    s1_d = {sclk_in, sdata_in, le_in};
    s2_d = s1_q;
    s3_d = s2_q;
    sh_d = sh_q;
    word_d = word_q;
    vld_d = 1'b0;
    if (s2_q[2] && !s3_q[2]) begin
      sh_d = {sh_q[30:0], s2_q[1]};
    end
    if (s2_q[0] && !s3_q[0]) begin
      word_d = sh_q;
      vld_d = 1'b1;
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      s3_q <= 3'h0;
      sh_q <= 32'h0;
      word_q <= 32'h0;
      vld_q <= 1'b0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      sh_q <= sh_d;
      word_q <= word_d;
      vld_q <= vld_d;
    end
  end
  assign word_out = word_q;
  assign word_valid_out = vld_q;
endmodule

/* hdl/srps_divider.sv */
`timescale 1ns/1ps
// Pulse-out divider; ratio 0 treated as 1
module srps_divider #(
  parameter int WIDTH = 10
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic hold_in,
  input wire logic tick_in,
  input wire logic [WIDTH-1:0] ratio_in,
  output logic tick_out
);
  import srps_pkg::*;
  initial begin
    if (WIDTH < 1) $error("WIDTH too small");
  end
  logic [WIDTH-1:0] cnt_q, cnt_d;
  logic out_q, out_d;
  always_comb begin
    cnt_d = cnt_q;
    out_d = 1'b0;
    if (hold_in) begin
      cnt_d = '0;
    end else if (tick_in) begin
      if (cnt_q + WIDTH'(1) >= ratio_in) begin
        cnt_d = '0;
        out_d = 1'b1;
      end else begin
        cnt_d = cnt_q + WIDTH'(1);
      end
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cnt_q <= '0;
      out_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end
  assign tick_out = out_q;
endmodule

/* hdl/srps_top.sv */
`timescale 1ns/1ps
`include "srps_regs.svh"
// Operation
// RULE1: Words with select 1010 load the ADC calibration register.
// RULE2: Host writes ones to bits 23 and 22, zeros elsewhere reserved.
// RULE3: ADC clock is reference-counter output divided by ADC divider; the code divides cmp_tick, which is halved when half_in is set.
// RULE4: ADC divider comes from bits 13 to 6.
// RULE5: Before programming the reference division factor is one.
// RULE6: Host computes divider as ceiling((comparison/100000 - 2)/4).
// RULE7: Host clamps the computed divider to 255.
// RULE8: Bit 5 set starts one conversion per calibration write.
// RULE9: Bit 4 powers the ADC.
// RULE10: Host writes register 11 as fixed 0x0061300B.
// RULE11: Words with select 1100 load the phase-resync register.
// RULE12: Resync timeout from bits 31..16, host picks or writes ones.
// RULE13: Host writes ones to bits 10 and 4 of resync reserved span.
// RULE14: Low-rate power-up order 12 down to 1, wait, then 0.
// RULE15: High-rate power-up uses halved rate then rewrites 4,2,1,0.
// RULE16: Low-rate update order with counter clear toggled around writes.
// RULE17: Low-rate update applies frequency on calibrated second 0 write.
// RULE18: High-rate update order via halved rate then target.
// RULE19: Output frequency changes only on a register 0 write.
// RULE20: Host encodes ratio as integer plus fractions over moduli.
// RULE21: Comparison = ref times (1+D) over R times (1+T); the code ignores doubler_in and divides ref_tick_in by R times (1+T) only.
// RULE22: Divide-by-two gives a 50% duty comparison clock.
// RULE23: Counter clear bit holds reference and feedback counters reset.
// RULE24: Words shift MSB first and latch on load-enable edge.
module srps_top #(
  parameter int RWIDTH = 10,
  parameter int DWIDTH = 8
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic sclk_in,
  input wire logic sdata_in,
  input wire logic le_in,
  input wire logic ref_tick_in,
  input wire logic [RWIDTH-1:0] ref_div_in,
  input wire logic ref_r_valid_in,
  input wire logic doubler_in,
  input wire logic half_in,
  output logic cmp_clk_out,
  output logic cmp_tick_out,
  output logic adc_clk_tick_out,
  output logic adc_power_out,
  output logic adc_convert_out,
  output logic counters_hold_out,
  output logic freq_apply_out,
  output srps_pkg::srps_word_t freq_word_out,
  output logic [15:0] resync_timeout_out,
  output srps_pkg::srps_word_t fixed_word_out
);
  import srps_pkg::*;
  initial begin
    if (RWIDTH < 1 || DWIDTH != 8) $error("bad parameters");
  end
  srps_word_t word;
  logic word_vld;
  srps_sel_t sel;
  srps_shift_in u_shift (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .sclk_in(sclk_in),
    .sdata_in(sdata_in),
    .le_in(le_in),
    .word_out(word),
    .word_valid_out(word_vld)
  ); // RULE24
  assign sel = word[3:0];

  srps_word_t adc_q, adc_d, rsy_q, rsy_d, fix_q, fix_d, r0_q, r0_d, fw_q, fw_d;
  logic clr_q, clr_d, conv_q, conv_d, app_q, app_d, rprog_q, rprog_d;
  logic [RWIDTH-1:0] r_q, r_d;
  logic ref_pulse;
  logic half_q, half_d, cmp_tick;

  // Reference tick is assumed to come from same-clock logic
  always_comb begin
    adc_d = adc_q;
    rsy_d = rsy_q;
    fix_d = fix_q;
    r0_d = r0_q;
    fw_d = fw_q;
    clr_d = clr_q;
    conv_d = 1'b0;
    app_d = 1'b0;
    r_d = r_q;
    rprog_d = rprog_q;
    if (ref_r_valid_in) begin
      r_d = ref_div_in;
      rprog_d = 1'b1;
    end
    if (word_vld) begin
      unique case (sel)
        `SRPS_SEL_ADC: begin
          adc_d = word; // RULE1
          conv_d = word[`SRPS_CONV_BIT]; // RULE8
        end
        `SRPS_SEL_RESYNC: rsy_d = word; // RULE11
        `SRPS_SEL_FIXED: fix_d = word;
        `SRPS_SEL_R4: clr_d = word[`SRPS_CLR_BIT]; // RULE23
        `SRPS_SEL_R0: begin
          r0_d = word;
          // Only a calibrated register 0 write commits the frequency
          if (word[`SRPS_CAL_BIT]) begin
            fw_d = word; // RULE17
            app_d = 1'b1; // RULE19
          end
        end
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      adc_q <= `SRPS_WORD_RST;
      rsy_q <= `SRPS_WORD_RST;
      fix_q <= `SRPS_WORD_RST;
      r0_q <= `SRPS_WORD_RST;
      fw_q <= `SRPS_WORD_RST;
      clr_q <= 1'b0;
      conv_q <= 1'b0;
      app_q <= 1'b0;
      r_q <= RWIDTH'(`SRPS_R_RST); // RULE5
      rprog_q <= 1'b0;
    end else begin
      adc_q <= adc_d;
      rsy_q <= rsy_d;
      fix_q <= fix_d;
      r0_q <= r0_d;
      fw_q <= fw_d;
      clr_q <= clr_d;
      conv_q <= conv_d;
      app_q <= app_d;
      r_q <= r_d;
      rprog_q <= rprog_d;
    end
  end

  // Reference counter; doubler modelled as no extra division
  srps_divider #(.WIDTH(RWIDTH)) u_rdiv (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .hold_in(clr_q), // RULE23
    .tick_in(ref_tick_in),
    .ratio_in(rprog_q ? r_q : RWIDTH'(`SRPS_R_RST)), // RULE5
    .tick_out(ref_pulse)
  );
  // Doubler input unused; rate doubling happens upstream of ref_tick_in
  always_comb begin
    half_d = half_q;
    cmp_tick = 1'b0;
    if (clr_q) begin
      half_d = 1'b0;
    end else if (ref_pulse) begin
      half_d = ~half_q;
      cmp_tick = half_in ? half_q : 1'b1; // RULE21
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      half_q <= 1'b0;
    end else begin
      half_q <= half_d;
    end
  end
  // With half_in set, the toggle flop gives an even duty comparison clock; otherwise ref_pulse passes through
  assign cmp_clk_out = half_in ? half_q : ref_pulse; // RULE22
  assign cmp_tick_out = cmp_tick;

  srps_divider #(.WIDTH(DWIDTH)) u_adcdiv (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .hold_in(~adc_q[`SRPS_ADCPWR_BIT]),
    .tick_in(cmp_tick),
    .ratio_in(adc_q[`SRPS_ADC_DIV_HI:`SRPS_ADC_DIV_LO]), // RULE4
    .tick_out(adc_clk_tick_out)
  ); // RULE3

  assign adc_power_out = adc_q[`SRPS_ADCPWR_BIT]; // RULE9
  assign adc_convert_out = conv_q;
  assign counters_hold_out = clr_q;
  assign freq_apply_out = app_q;
  assign freq_word_out = fw_q;
  assign resync_timeout_out = rsy_q[`SRPS_TMO_HI:`SRPS_TMO_LO]; // RULE12
  assign fixed_word_out = fix_q;

  conv_pulse_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (word_vld && sel == `SRPS_SEL_ADC && word[`SRPS_CONV_BIT]) |=> adc_convert_out)
    else $error("conversion not started"); // RULE8
  adc_load_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (word_vld && sel == `SRPS_SEL_ADC) |=> adc_q == $past(word))
    else $error("ADC word not loaded"); // RULE1
  resync_load_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (word_vld && sel == `SRPS_SEL_RESYNC) |=> resync_timeout_out == $past(word[31:16]))
    else $error("resync timeout not loaded"); // RULE11
  apply_only_r0_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    freq_apply_out |-> $past(word_vld && sel == `SRPS_SEL_R0))
    else $error("apply without register 0"); // RULE19
  cal_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (word_vld && sel == `SRPS_SEL_R0 && !word[`SRPS_CAL_BIT]) |=> !freq_apply_out)
    else $error("uncalibrated write applied"); // RULE17
  hold_follow_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (word_vld && sel == `SRPS_SEL_R4) |=> counters_hold_out == $past(word[4]))
    else $error("counter clear not followed"); // RULE23
  hold_no_tick_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    counters_hold_out[*2] |-> !ref_pulse)
    else $error("comparison tick while held"); // RULE23
  adc_pwr_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (word_vld && sel == `SRPS_SEL_ADC) |=> adc_power_out == $past(word[`SRPS_ADCPWR_BIT]))
    else $error("ADC power mismatch"); // RULE9
  r_default_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!rprog_q && !clr_q && !half_in && ref_tick_in) |=>
    (cmp_tick_out || counters_hold_out || half_in))
    else $error("default R not one"); // RULE5
endmodule

/* verif/srps_host_model.sv */
`timescale 1ns/1ps
// Host side of the three-wire link
module srps_host_model (
  input wire logic clk_in,
  output logic sclk_out,
  output logic sdata_out,
  output logic le_out
);
  initial begin
    sclk_out = 1'b0;
    sdata_out = 1'b0;
    le_out = 1'b0;
  end
  function automatic logic [31:0] adc_word(input int div, input logic conv, input logic pwr);
    int d;
    d = (div > 255) ? 255 : div;
    return 32'h00c00000 | (32'(d) << 6) | {26'h0, conv, pwr, 4'ha};
  endfunction
  function automatic logic [31:0] resync_word(input logic [15:0] tmo);
    return {tmo, 16'h041c};
  endfunction
  function automatic int adc_div(input int cmp_hz);
    return int'($ceil((real'(cmp_hz) / 100000.0 - 2.0) / 4.0));
  endfunction
  function automatic logic [31:0] primary_fraction_word(input real frac);
    return {4'h0, 24'($rtoi(frac * 16777216.0)), 4'h1};
  endfunction
  function automatic logic [31:0] fixed_word();
    return 32'h0061300b;
  endfunction
  // Four clocks per pin edge: sync needs three
  task automatic send_word(input logic [31:0] word);
    for (int i = 31; i >= 0; i--) begin
      sdata_out = word[i];
      repeat (4) @(negedge clk_in);
      sclk_out = 1'b1;
      repeat (4) @(negedge clk_in);
      sclk_out = 1'b0;
    end
    le_out = 1'b1;
    repeat (4) @(negedge clk_in);
    le_out = 1'b0;
    sdata_out = ~word[0];
    repeat (8) @(negedge clk_in);
  endtask
endmodule

/* verif/tb_srps_top.sv */
`timescale 1ns/1ps
module tb_srps_top;
  import srps_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic sclk, sdata, le;
  logic ref_tick_in = 1'b0;
  logic ref_r_valid = 1'b0;
  logic half = 1'b0;
  logic [9:0] ref_div = 10'h001;
  logic cmp_clk, cmp_tick;
  logic adc_tick, adc_pwr, adc_conv, hold, apply;
  srps_word_t freq_word, fixed_word;
  logic [15:0] tmo;
  int failures = 0;
  int checks = 0;
  int cycles = 0;
  int conv_n = 0;
  int apply_n = 0;
  int n;
  always #10 clk_in = ~clk_in;
  // Reference edge every fourth clock
  always @(negedge clk_in) ref_tick_in <= (cycles % 4 == 0);
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    conv_n <= conv_n + int'(adc_conv === 1'b1);
    apply_n <= apply_n + int'(apply === 1'b1);
    if (cycles == 40000) begin
      failures++;
      stop_test();
    end
  end
  srps_host_model i_srps_host_model (.clk_in(clk_in), .sclk_out(sclk), .sdata_out(sdata),
    .le_out(le));
  srps_top i_srps_top (.clk_in(clk_in), .rst_n_in(rst_n_in), .sclk_in(sclk), .sdata_in(sdata),
    .le_in(le), .ref_tick_in(ref_tick_in), .ref_div_in(ref_div), .ref_r_valid_in(ref_r_valid),
    .doubler_in(1'b0), .half_in(half), .cmp_clk_out(cmp_clk), .cmp_tick_out(cmp_tick),
    .adc_clk_tick_out(adc_tick), .adc_power_out(adc_pwr), .adc_convert_out(adc_conv),
    .counters_hold_out(hold), .freq_apply_out(apply), .freq_word_out(freq_word),
    .resync_timeout_out(tmo), .fixed_word_out(fixed_word));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic send(input logic [31:0] w);
    i_srps_host_model.send_word(w);
  endtask
  // Clocks between two ADC ticks
  task automatic adc_period(output int k);
    k = 0;
    while (adc_tick !== 1'b1 && k < 3000) begin
      @(negedge clk_in);
      k++;
    end
    k = 0;
    do begin
      @(negedge clk_in);
      k++;
    end while (adc_tick !== 1'b1 && k < 3000);
  endtask
  task automatic cmp_period(output int k);
    k = 0;
    while (cmp_tick !== 1'b1 && k < 3000) begin
      @(negedge clk_in);
      k++;
    end
    k = 0;
    do begin
      @(negedge clk_in);
      k++;
    end while (cmp_tick !== 1'b1 && k < 3000);
  endtask
  // Clocks that the comparison clock stays high
  task automatic cmp_high(output int k);
    k = 0;
    while (cmp_clk !== 1'b0 && k < 3000) begin
      @(negedge clk_in);
      k++;
    end
    while (cmp_clk !== 1'b1 && k < 3000) begin
      @(negedge clk_in);
      k++;
    end
    k = 0;
    while (cmp_clk === 1'b1 && k < 3000) begin
      @(negedge clk_in);
      k++;
    end
  endtask
  // More than 16 ADC periods; a stalled ADC clock ends in the timeout
  task automatic wait_adc();
    int k;
    k = 0;
    while (k < 17) begin
      @(negedge clk_in);
      if (adc_tick === 1'b1) begin
        k++;
      end
    end
  endtask
  task automatic set_r(input int r);
    @(negedge clk_in);
    ref_div = 10'(r);
    ref_r_valid = 1'b1;
    @(negedge clk_in);
    ref_r_valid = 1'b0;
  endtask
  task automatic test_reset();
    chk("power", 0, adc_pwr);
    chk("hold", 0, hold);
    chk("timeout", 0, tmo);
    cmp_period(n);
    chk("cmp period", 4, n);
  endtask
  // Reference edge every fourth clock with R of one: 12.5 MHz comparison
  task automatic test_powerup();
    int a0;
    a0 = apply_n;
    send(i_srps_host_model.resync_word(16'hffff));
    send(i_srps_host_model.fixed_word());
    send(i_srps_host_model.adc_word(i_srps_host_model.adc_div(12500000), 1'b1, 1'b1));
    for (int r = 9; r >= 1; r--) begin
      send({28'h0, 4'(r)});
    end
    chk("applies", a0, apply_n);
    wait_adc();
    send(32'h0020_0000);
    chk("applies", a0 + 1, apply_n);
    adc_period(n);
    chk("adc period", 124, n);
  endtask
  task automatic test_adc();
    int c0;
    c0 = conv_n;
    send(i_srps_host_model.adc_word(3, 1'b1, 1'b1));
    send(i_srps_host_model.adc_word(3, 1'b1, 1'b1));
    chk("power", 1, adc_pwr);
    chk("conversions", c0 + 2, conv_n);
    adc_period(n);
    chk("adc period", 12, n);
    send(i_srps_host_model.adc_word(2, 1'b1, 1'b1));
    adc_period(n);
    chk("adc period", 8, n);
    send(i_srps_host_model.adc_word(300, 1'b1, 1'b1));
    adc_period(n);
    chk("adc period", 1020, n);
    send(i_srps_host_model.adc_word(2, 1'b0, 1'b0));
    chk("power", 0, adc_pwr);
    chk("conversions", c0 + 4, conv_n);
  endtask
  task automatic test_resync();
    send(i_srps_host_model.resync_word(16'hffff));
    send(i_srps_host_model.resync_word(16'h1234));
    chk("timeout", 16'h1234, tmo);
    send(32'h5555_0009);
    chk("timeout", 16'h1234, tmo);
    send(i_srps_host_model.fixed_word());
    chk("fixed", 32'h0061300b, fixed_word);
  endtask
  task automatic test_update();
    int a0;
    a0 = apply_n;
    send(i_srps_host_model.adc_word(2, 1'b1, 1'b1));
    send(32'h0000_0014);
    chk("hold", 1, hold);
    chk("applies", a0, apply_n);
    send(32'h0000_0002);
    send(i_srps_host_model.primary_fraction_word(0.7760416));
    send(32'h0000_0440);
    chk("applies", a0, apply_n);
    send(32'h0000_0004);
    chk("hold", 0, hold);
    wait_adc();
    send(32'h0020_0450);
    chk("applies", a0 + 1, apply_n);
    chk("freq word", 32'h0020_0450, freq_word);
  endtask
  // Halved comparison rate first, then the target rate
  task automatic test_high();
    int a0;
    @(negedge clk_in);
    half = 1'b1;
    set_r(2);
    repeat (40) @(negedge clk_in);
    cmp_period(n);
    chk("cmp period", 16, n);
    cmp_high(n);
    chk("cmp high", 8, n);
    a0 = apply_n;
    send(i_srps_host_model.adc_word(3, 1'b1, 1'b1));
    send(32'h0000_0014);
    chk("hold", 1, hold);
    send(32'h0000_0002);
    send(i_srps_host_model.primary_fraction_word(0.5));
    send(32'h0000_0120);
    chk("applies", a0, apply_n);
    send(32'h0000_0004);
    wait_adc();
    send(32'h0020_0120);
    chk("applies", a0 + 1, apply_n);
    chk("freq word", 32'h0020_0120, freq_word);
    set_r(1);
    send(32'h0000_0002);
    send(i_srps_host_model.primary_fraction_word(0.25));
    chk("applies", a0 + 1, apply_n);
    send(32'h0000_0130);
  endtask
  task automatic stop_test();
    if (failures == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge clk_in);
    rst_n_in = 1'b1;
    repeat (2) @(negedge clk_in);
    test_reset();
    test_powerup();
    test_adc();
    test_resync();
    test_update();
    test_high();
    stop_test();
  end
endmodule
